//--- dv/stpl_ctrl.sv
// Controller model driving the serial data, both clocks and control pins
`timescale 1ns/1ps
module stpl_ctrl
(
   output logic shift_clock,
   output logic storage_load_clock,
   output logic shift_data_input,
   output logic shift_clear_n,
   output logic output_enable_n
);
   initial
   begin
      shift_clock = 1'b0;
      storage_load_clock = 1'b0;
      shift_data_input = 1'b0;
      shift_clear_n = 1'b1;
      output_enable_n = 1'b1;
   end
   task automatic set_pins(input logic clr_n, input logic oe_n);
      shift_clear_n = clr_n;
      output_enable_n = oe_n;
   endtask : set_pins
   // Data moves only while clocks are low; clocks rest low between frames
   task automatic pulse(input logic s, input logic l, input logic d);
      shift_data_input = d;
      #62.5;
      shift_clock = s;
      storage_load_clock = l;
      #62.5;
      shift_clock = 1'b0;
      storage_load_clock = 1'b0;
   endtask : pulse
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         pulse(1'b1, 1'b0, b[i]);
   endtask : send_byte
endmodule : stpl_ctrl

//--- dv/test_serial_to_parallel_latch.sv
// Self-checking bench for the serial-to-parallel latch
`timescale 1ns/1ps
module test_serial_to_parallel_latch;
   import stpl_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic sck, lck, sdat, clr_n, oe_n, casc;
   stpl_byte_t po, po_oe_n, b;
   logic [16:0] notes[$];
   int fails = 0;
   int tests_run = 0;
   int seed = 32'h0097;
   event chk;
   stpl_ctrl i_ctrl (.shift_clock(sck), .storage_load_clock(lck),
      .shift_data_input(sdat), .shift_clear_n(clr_n),
      .output_enable_n(oe_n));
   stpl_latch i_dut (.clk_sys(clk_sys), .nrst(nrst), .shift_clock(sck),
      .storage_load_clock(lck), .shift_data_input(sdat),
      .shift_clear_n(clr_n), .output_enable_n(oe_n),
      .parallel_outputs(po), .parallel_outputs_oe_n(po_oe_n),
      .cascade_out(casc));
   initial
      forever #5 clk_sys = ~clk_sys;
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH outputs expected %h seen %h", exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("Checks run %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   // Note first, then let the pin-sync latency pass before sampling
   task automatic expect_out(input logic [16:0] e);
      notes.push_back(e);
      repeat (6) @(negedge clk_sys);
      ->chk;
   endtask : expect_out
   always @(chk)
      check({po_oe_n, po, casc}, notes.pop_front());
   initial
   begin
      #1ms;
      fails++;
      finish_test();
   end
   initial
   begin
      repeat (10) @(negedge clk_sys);
      nrst = 1'b1;
      expect_out({8'hFF, 8'h00, 1'b0});
      i_ctrl.set_pins(1'b1, 1'b0);
      b = 8'($random(seed));
      i_ctrl.send_byte(b);
      expect_out({8'h00, 8'h00, b[7]});
      i_ctrl.pulse(1'b0, 1'b1, ~b[0]);
      expect_out({8'h00, b, b[7]});
      // Shared edge: storage keeps the pre-edge shift contents
      i_ctrl.pulse(1'b1, 1'b1, 1'b1);
      expect_out({8'h00, b, b[6]});
      i_ctrl.pulse(1'b0, 1'b1, 1'b0);
      expect_out({8'h00, b[6:0], 1'b1, b[6]});
      i_ctrl.set_pins(1'b0, 1'b0);
      i_ctrl.pulse(1'b1, 1'b0, 1'b1);
      i_ctrl.set_pins(1'b1, 1'b0);
      expect_out({8'h00, b[6:0], 1'b1, 1'b0});
      i_ctrl.pulse(1'b0, 1'b1, 1'b1);
      i_ctrl.set_pins(1'b1, 1'b1);
      expect_out({8'hFF, 8'h00, 1'b0});
      i_ctrl.set_pins(1'b1, 1'b0);
      repeat (3)
      begin
         b = 8'($random(seed));
         i_ctrl.send_byte(b);
         i_ctrl.pulse(1'b0, 1'b1, 1'b0);
         expect_out({8'h00, b, b[7]});
      end
      finish_test();
   end
endmodule : test_serial_to_parallel_latch

//--- rtl/stpl_consts.svh
// Constants for the serial-to-parallel latch block
`ifndef STPL_CONSTS_SVH
`define STPL_CONSTS_SVH
`define STPL_WIDTH 8
`define STPL_SYNC_STAGES 2
`define STPL_ZERO_BYTE 8'h00
`define STPL_SYNC_IDLE 5'h18
`endif

//--- rtl/stpl_edge_if.sv
// Interface carrying synchronised pin levels and their rising edges
`timescale 1ns/1ps
interface stpl_edge_if;
   logic shift_rise;
   logic load_rise;
   logic data_level;
   logic clear_level_n;
   logic oe_level_n;
   modport src (output shift_rise, output load_rise, output data_level,
      output clear_level_n, output oe_level_n);
   modport dst (input shift_rise, input load_rise, input data_level,
      input clear_level_n, input oe_level_n);
endinterface : stpl_edge_if

//--- rtl/stpl_latch.sv
// Serial-in, parallel-out shift register with storage register
`timescale 1ns/1ps
`include "stpl_consts.svh"
// Contract
// - Eight-bit shift register takes one serial bit per shift.
// - Storage register, not shift register, drives the parallel outputs.
// - Shift and storage registers each have their own independent clock.
// - Shifting and storage loads happen only on rising clock edges.
// - Clear acts without a clock edge, overrides shifting, spares storage.
// - Clear is active low and holds the shift register cleared.
// - Last shift stage is driven out on a cascade output.
// - Common clock: storage takes shift contents from before the edge.
module stpl_latch
   import stpl_pkg::*;
#(
   parameter int WIDTH = `STPL_WIDTH
)
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic shift_clock,
   input wire logic storage_load_clock,
   input wire logic shift_data_input,
   input wire logic shift_clear_n,
   input wire logic output_enable_n,
   output logic [WIDTH-1:0] parallel_outputs,
   output logic [WIDTH-1:0] parallel_outputs_oe_n,
   output logic cascade_out
);
   stpl_edge_if edges ();

   logic [WIDTH-1:0] shift_r;
   logic [WIDTH-1:0] shift_nxt;
   logic [WIDTH-1:0] store_r;
   logic [WIDTH-1:0] store_nxt;
   logic [WIDTH-1:0] oe_n_r;
   logic [WIDTH-1:0] oe_n_nxt;
   logic cascade_r;
   logic cascade_nxt;

   stpl_pin_sync u_sync
   (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .shift_clock(shift_clock),
      .storage_load_clock(storage_load_clock),
      .shift_data_input(shift_data_input),
      .shift_clear_n(shift_clear_n),
      .output_enable_n(output_enable_n),
      .edges(edges)
   );

   // One shift step: stage zero takes the serial bit, the rest move up
   function automatic logic [WIDTH-1:0] shift_step(
      input logic [WIDTH-1:0] stages,
      input logic bit_in
   );
      shift_step = {stages[WIDTH-2:0], bit_in};
   endfunction : shift_step

   // Shift stages. Clear passes the synchroniser like every pin, so it
   // acts within the sync latency rather than at once; a shift edge seen
   // in the same cycle still loses to it.
   always_comb
   begin
      shift_nxt = shift_r;
      if (!edges.clear_level_n)
         shift_nxt = `STPL_ZERO_BYTE;
      else if (edges.shift_rise)
         shift_nxt = shift_step(shift_r, edges.data_level);
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         shift_r <= `STPL_ZERO_BYTE;
      else
         shift_r <= shift_nxt;
   end

   // Storage takes the stages as they stood before the edge, so a shared
   // clock leaves the outputs one step behind the shift register.
   always_comb
   begin
      store_nxt = store_r;
      if (edges.load_rise)
         store_nxt = shift_r;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         store_r <= `STPL_ZERO_BYTE;
      else
         store_r <= store_nxt;
   end

   // One enable for all pins, kept per pin so each pad has its own flop
   always_comb
   begin
      oe_n_nxt = {WIDTH{edges.oe_level_n}};
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         oe_n_r <= {WIDTH{1'b1}};
      else
         oe_n_r <= oe_n_nxt;
   end

   // Registered copy of the last stage, so the pin comes from a flop
   always_comb
   begin
      cascade_nxt = shift_nxt[WIDTH-1];
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         cascade_r <= 1'b0;
      else
         cascade_r <= cascade_nxt;
   end

   assign parallel_outputs = store_r;
   assign parallel_outputs_oe_n = oe_n_r;
   assign cascade_out = cascade_r;

   // Checks work on the synchronised pin view, one clk_sys step at a time
   clear_holds_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !edges.clear_level_n |=> shift_r == `STPL_ZERO_BYTE)
      else $error("shift register not cleared");

   clear_wins_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (!edges.clear_level_n && edges.shift_rise) |=> cascade_r == 1'b0)
      else $error("shift beat clear");

   shift_moves_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (edges.clear_level_n && edges.shift_rise) |=>
      shift_r == shift_step($past(shift_r), $past(edges.data_level)))
      else $error("shift stage wrong");

   shift_steady_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (edges.clear_level_n && !edges.shift_rise) |=> $stable(shift_r))
      else $error("shift without edge");

   load_old_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      edges.load_rise |=> parallel_outputs == $past(shift_r))
      else $error("storage load wrong");

   store_steady_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !edges.load_rise |=> $stable(store_r))
      else $error("storage changed without edge");

   cascade_tail_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      cascade_out == shift_r[WIDTH-1])
      else $error("cascade mismatch");

   oe_follow_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      edges.oe_level_n |=> parallel_outputs_oe_n == {WIDTH{1'b1}})
      else $error("outputs not released");

   clear_keeps_store_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (!edges.clear_level_n && !edges.load_rise) |=> $stable(store_r))
      else $error("clear hit storage");

   oe_drive_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !edges.oe_level_n |=> parallel_outputs_oe_n == '0)
      else $error("outputs not driven");

   cascade_clear_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !edges.clear_level_n |=> cascade_out == 1'b0)
      else $error("cascade not cleared");

   first_stage_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (edges.clear_level_n && edges.shift_rise) |=>
      shift_r[0] == $past(edges.data_level))
      else $error("first stage missed serial bit");

   stages_move_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (edges.clear_level_n && edges.shift_rise) |=>
      shift_r[WIDTH-1:1] == $past(shift_r[WIDTH-2:0]))
      else $error("stages did not move up");

   // A shared edge must leave the shift register one step ahead
   common_edge_a: assert property (
      @(posedge clk_sys) disable iff (!nrst) (edges.clear_level_n &&
      edges.shift_rise && edges.load_rise) |=>
      shift_r[WIDTH-1:1] == parallel_outputs[WIDTH-2:0])
      else $error("shared edge order wrong");

   cascade_shift_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (edges.clear_level_n && edges.shift_rise) |=>
      cascade_out == $past(shift_r[WIDTH-2]))
      else $error("cascade did not follow shift");

   load_alone_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (edges.shift_rise && !edges.load_rise) |=> $stable(parallel_outputs))
      else $error("shift clock moved storage");

   // Edge strobes last one cycle, so one pin edge acts exactly once
   shift_pulse_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      edges.shift_rise |=> !edges.shift_rise)
      else $error("shift strobe too long");

   load_pulse_a: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      edges.load_rise |=> !edges.load_rise)
      else $error("load strobe too long");
endmodule : stpl_latch

//--- rtl/stpl_pin_sync.sv
// Two-flop synchronisers and rising-edge detection for the pin inputs
`timescale 1ns/1ps
`include "stpl_consts.svh"
module stpl_pin_sync
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic shift_clock,
   input wire logic storage_load_clock,
   input wire logic shift_data_input,
   input wire logic shift_clear_n,
   input wire logic output_enable_n,
   stpl_edge_if.src edges
);
   // Order: shift clk, load clk, data, clear_n, oe_n
   logic [4:0] meta_r;
   logic [4:0] sync_r;
   logic [4:0] prev_r;
   logic [4:0] meta_nxt;
   logic [4:0] sync_nxt;
   logic [4:0] prev_nxt;

   always_comb
   begin
      meta_nxt = {output_enable_n, shift_clear_n, shift_data_input,
         storage_load_clock, shift_clock};
      sync_nxt = meta_r;
      prev_nxt = sync_r;
   end

   // Clear and enable idle high so nothing fires while in reset
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_r <= `STPL_SYNC_IDLE;
         sync_r <= `STPL_SYNC_IDLE;
         prev_r <= `STPL_SYNC_IDLE;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign edges.shift_rise = sync_r[0] & ~prev_r[0];
   assign edges.load_rise = sync_r[1] & ~prev_r[1];
   assign edges.data_level = sync_r[2];
   assign edges.clear_level_n = sync_r[3];
   assign edges.oe_level_n = sync_r[4];
endmodule : stpl_pin_sync

//--- rtl/stpl_pkg.sv
// Types shared by the serial-to-parallel latch design files
`include "stpl_consts.svh"
package stpl_pkg;
   typedef logic [`STPL_WIDTH-1:0] stpl_byte_t;
endpackage : stpl_pkg
